// ===== shared/crc_pkg.sv
// Package for the byte-wide CRC-16 calculator.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package crc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_CTRL     = 4'h0;
    localparam logic [3:0]  ADDR_LOW      = 4'h4;
    localparam logic [3:0]  ADDR_HIGH     = 4'h8;
    localparam logic [3:0]  ADDR_STATUS   = 4'hc;
    localparam int          ADDR_W        = 4;

    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int          CTRL_RST_BIT  = 0;
    localparam int          CTRL_INIT_BIT = 1;
    localparam int          CTRL_ORD_BIT  = 2;
    localparam logic [15:0] POLY          = 16'h1021;
    localparam logic [15:0] INIT_ZERO     = 16'h0000;
    localparam logic [15:0] INIT_ONES     = 16'hffff;
    localparam logic [15:0] RESULT_RESET  = 16'h0000;
    localparam logic [2:0]  CTRL_RESET    = 3'h0;
    localparam logic [3:0]  BIT_COUNT     = 4'h8;

    typedef enum logic [1:0] {
        CRC_IDLE,
        CRC_BUSY
    } crc_state_t;

endpackage : crc_pkg

// ===== core/crc_step.sv
// One bit step of the CRC-16 shift register.
// Assumes the caller picks the input bit in the chosen bit order.
module crc_step (
    input  wire logic [15:0] crc_in,
    input  wire logic        data_bit,
    output logic      [15:0] crc_out
);

    // ------------------------------------------------------------
    // Feedback step
    // ------------------------------------------------------------
    always_comb begin
        if (crc_in[15] ^ data_bit) begin
            crc_out = {crc_in[14:0], 1'b0} ^ crc_pkg::POLY; // RULE_07
        end else begin
            crc_out = {crc_in[14:0], 1'b0};
        end
    end

endmodule : crc_step

// ===== core/crc_calc.sv
// APB-attached byte-wide CRC-16 calculator.
// Assumes a synchronous APB master on the same 10 MHz clock.
//
// Function
// RULE_01: Writing a byte to the low register starts one calculation over it.
// RULE_02: Reading the low register returns the result's low byte.
// RULE_03: Writes to the high register change nothing.
// RULE_04: Reading the high register returns the result's high byte.
// RULE_05: Each byte folds into the running result since the last calculator reset.
// RULE_06: Calculation ends by itself and the engine returns to idle.
// RULE_07: The update uses generator polynomial 0x1021.
// RULE_08: Init select picks zeros or ones, applied only at a calculator reset.
// RULE_09: Writing one to the reset bit loads the initial value; bit self-clears.
// RULE_10: Order bit zero processes MSB first, one processes LSB first.
// RULE_11: The new result is visible by the next bus access after a write.
module crc_calc (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    crc_pkg::crc_state_t state_reg, state_next;
    logic [15:0] result_reg, result_next;
    logic [7:0]  data_reg, data_next;
    logic [3:0]  count_reg, count_next;
    logic        init_sel_reg, init_sel_next;
    logic        order_reg, order_next;
    logic        pready_reg, pready_next;
    logic        pslverr_reg, pslverr_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [15:0] step_out;
    logic        step_bit;
    logic        request;
    logic        hit;
    logic        access_wr;
    logic [3:0]  addr;

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign addr    = paddr[3:0];

    function automatic logic mapped(input logic [31:0] a);
        mapped = (a[31:4] == 28'h0) && (a[1:0] == 2'h0);
    endfunction : mapped

    assign hit = mapped(paddr);

    // ------------------------------------------------------------
    // Bit engine
    // ------------------------------------------------------------
    assign step_bit = order_reg ? data_reg[0] : data_reg[7]; // RULE_10

    crc_step u_step (
        .crc_in   (result_reg),
        .data_bit (step_bit),
        .crc_out  (step_out)
    );

    // ------------------------------------------------------------
    // Bus slave and calculator
    // ------------------------------------------------------------
    // A request that arrives while the engine is busy is held off, in setup or access phase alike,
    // until the engine is idle, so a read never sees a half-finished result.
    assign request   = psel && !pready_reg; // RULE_11
    assign access_wr = psel && penable && pready_reg && pwrite && hit;

    always_comb begin
        state_next    = state_reg;
        result_next   = result_reg;
        data_next     = data_reg;
        count_next    = count_reg;
        init_sel_next = init_sel_reg;
        order_next    = order_reg;
        pready_next   = 1'b0;
        pslverr_next  = 1'b0;
        prdata_next   = prdata_reg;
        case (state_reg)
            crc_pkg::CRC_IDLE: begin
                if (request) begin
                    pready_next  = 1'b1;
                    pslverr_next = !mapped(paddr);
                    prdata_next  = 32'h0;
                    if (!pwrite && hit) begin
                        case (addr)
                            crc_pkg::ADDR_CTRL:   prdata_next = {29'h0, order_reg, init_sel_reg, 1'b0};
                            crc_pkg::ADDR_LOW:    prdata_next = {24'h0, result_reg[7:0]};  // RULE_02
                            crc_pkg::ADDR_HIGH:   prdata_next = {24'h0, result_reg[15:8]}; // RULE_04
                            crc_pkg::ADDR_STATUS: prdata_next = 32'h0;
                            default:              prdata_next = 32'h0;
                        endcase
                    end
                end
                if (access_wr) begin
                    case (addr)
                        crc_pkg::ADDR_CTRL: begin
                            order_next    = pwdata[crc_pkg::CTRL_ORD_BIT];
                            init_sel_next = pwdata[crc_pkg::CTRL_INIT_BIT]; // RULE_08
                            if (pwdata[crc_pkg::CTRL_RST_BIT]) begin
                                // The reset bit is never stored, so it reads back as zero.
                                result_next = pwdata[crc_pkg::CTRL_INIT_BIT] ? crc_pkg::INIT_ONES
                                                                             : crc_pkg::INIT_ZERO; // RULE_09
                            end
                        end
                        crc_pkg::ADDR_LOW: begin
                            data_next  = pwdata[7:0]; // RULE_01
                            count_next = crc_pkg::BIT_COUNT;
                            state_next = crc_pkg::CRC_BUSY;
                        end
                        default: begin
                            state_next = state_reg; // RULE_03
                        end
                    endcase
                end
            end
            crc_pkg::CRC_BUSY: begin
                result_next = step_out; // RULE_05
                data_next   = order_reg ? {1'b0, data_reg[7:1]} : {data_reg[6:0], 1'b0};
                count_next  = count_reg - 4'h1;
                if (count_reg == 4'h1) begin
                    state_next = crc_pkg::CRC_IDLE; // RULE_06
                end
            end
            default: begin
                state_next = crc_pkg::CRC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg    <= crc_pkg::CRC_IDLE;
            result_reg   <= crc_pkg::RESULT_RESET;
            data_reg     <= 8'h00;
            count_reg    <= 4'h0;
            init_sel_reg <= 1'b0;
            order_reg    <= 1'b0;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
            prdata_reg   <= 32'h0;
        end else begin
            state_reg    <= state_next;
            result_reg   <= result_next;
            data_reg     <= data_next;
            count_reg    <= count_next;
            init_sel_reg <= init_sel_next;
            order_reg    <= order_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
            prdata_reg   <= prdata_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_busy_length: assert property (@(posedge clock) disable iff (reset) // RULE_06
        (state_reg == crc_pkg::CRC_IDLE) ##1 (state_reg == crc_pkg::CRC_BUSY)
            |-> (state_reg == crc_pkg::CRC_BUSY) [*8] ##1 (state_reg == crc_pkg::CRC_IDLE))
        else $error("Calculation did not take eight cycles.");

    chk_low_write_starts: assert property (@(posedge clock) disable iff (reset) // RULE_01
        access_wr && addr == crc_pkg::ADDR_LOW |=> state_reg == crc_pkg::CRC_BUSY)
        else $error("Low write did not start a calculation.");

    chk_high_write_none: assert property (@(posedge clock) disable iff (reset) // RULE_03
        access_wr && addr == crc_pkg::ADDR_HIGH && state_reg == crc_pkg::CRC_IDLE |=> $stable(result_reg))
        else $error("High write changed the result.");

    chk_low_read_value: assert property (@(posedge clock) disable iff (reset) // RULE_02
        request && !pwrite && hit && addr == crc_pkg::ADDR_LOW && state_reg == crc_pkg::CRC_IDLE
            |=> prdata_reg == {24'h0, $past(result_reg[7:0])})
        else $error("Low read returned the wrong byte.");

    chk_high_read_value: assert property (@(posedge clock) disable iff (reset) // RULE_04
        request && !pwrite && hit && addr == crc_pkg::ADDR_HIGH && state_reg == crc_pkg::CRC_IDLE
            |=> prdata_reg == {24'h0, $past(result_reg[15:8])})
        else $error("High read returned the wrong byte.");

    chk_reset_loads: assert property (@(posedge clock) disable iff (reset) // RULE_09
        access_wr && addr == crc_pkg::ADDR_CTRL && pwdata[0]
            |=> result_reg == ($past(pwdata[1]) ? 16'hffff : 16'h0000))
        else $error("Calculator reset loaded the wrong value.");

    chk_ctrl_rst_zero: assert property (@(posedge clock) disable iff (reset) // RULE_09
        request && !pwrite && hit && addr == crc_pkg::ADDR_CTRL && state_reg == crc_pkg::CRC_IDLE
            |=> prdata_reg[0] == 1'b0)
        else $error("Calculator reset bit did not read back as zero.");

    chk_unmapped_none: assert property (@(posedge clock) disable iff (reset) // RULE_01
        psel && penable && pready_reg && pwrite && !hit && state_reg == crc_pkg::CRC_IDLE
            |=> $stable(result_reg) && state_reg == crc_pkg::CRC_IDLE)
        else $error("Unmapped write changed the calculator.");

    chk_init_sel_hold: assert property (@(posedge clock) disable iff (reset) // RULE_08
        access_wr && addr == crc_pkg::ADDR_CTRL && !pwdata[0] && state_reg == crc_pkg::CRC_IDLE
            |=> $stable(result_reg))
        else $error("Init select changed the result without a reset.");

    chk_no_answer_busy: assert property (@(posedge clock) disable iff (reset) // RULE_11
        state_reg == crc_pkg::CRC_BUSY |=> !pready_reg)
        else $error("Bus answered while a calculation ran.");

    chk_poly_step: assert property (@(posedge clock) disable iff (reset) // RULE_07
        state_reg == crc_pkg::CRC_BUSY && (result_reg[15] ^ step_bit)
            |=> result_reg == ({$past(result_reg[14:0]), 1'b0} ^ 16'h1021))
        else $error("Feedback step did not use the polynomial.");

    chk_order_bit: assert property (@(posedge clock) disable iff (reset) // RULE_10
        access_wr && addr == crc_pkg::ADDR_LOW
            |=> step_bit == (order_reg ? $past(pwdata[0]) : $past(pwdata[7])))
        else $error("Wrong input bit order.");

    chk_fold_running: assert property (@(posedge clock) disable iff (reset) // RULE_05
        state_reg == crc_pkg::CRC_BUSY && !(result_reg[15] ^ step_bit)
            |=> result_reg == {$past(result_reg[14:0]), 1'b0})
        else $error("Byte did not fold into the running result.");

endmodule : crc_calc

// ===== test/tb_crc_calc.sv
// Self-checking testbench for the APB byte-wide CRC-16 calculator.
// Assumes the register map and the field positions of crc_pkg, one 10 MHz clock and a synchronous reset.
module tb_crc_calc;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------
    // Signals and expectation queue
    // ------------------------------------------------------------
    typedef struct packed {logic is_rd; logic err; logic [31:0] data;} crc_note_t;

    logic        clock;
    logic        reset;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    crc_note_t   notes[$];
    crc_note_t   note;
    int          n_fail;
    int          n_tests;
    logic [15:0] model;
    logic [7:0]  b;

    localparam logic [31:0] A_CTRL = 32'(crc_pkg::ADDR_CTRL);
    localparam logic [31:0] A_LOW  = 32'(crc_pkg::ADDR_LOW);
    localparam logic [31:0] A_HIGH = 32'(crc_pkg::ADDR_HIGH);
    localparam logic [31:0] A_STAT = 32'(crc_pkg::ADDR_STATUS);

    crc_calc DUT (.clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
                  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task report_and_stop;
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    // The request is left standing so that a following call forms a back-to-back setup cycle.
    task apb(input logic wr, input logic [31:0] addr, input logic [31:0] data, input logic err,
             input logic [31:0] exp);
        int k;
        notes.push_back(crc_note_t'{is_rd: !wr, err: err, data: exp});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 30);
        if (k >= 30) begin
            n_fail++;
            report_and_stop();
        end
    endtask : apb

    task wr(input logic [31:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data, 1'b0, 32'h0000_0000);
    endtask : wr

    task rd(input logic [31:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000, 1'b0, exp);
    endtask : rd

    function automatic logic [15:0] crc_fold(input logic [15:0] c, input logic [7:0] d, input logic lsb);
        logic f;
        for (int i = 0; i < 8; i++) begin
            f = c[15] ^ (lsb ? d[i] : d[7 - i]);
            c = {c[14:0], 1'b0} ^ (f ? crc_pkg::POLY : 16'h0000);
        end
        return c;
    endfunction : crc_fold

    // ------------------------------------------------------------
    // Monitor: each answered access retires the oldest note.
    // ------------------------------------------------------------
    always @(posedge clock) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (notes.size() == 0) begin
                check(33'h0_0000_0000, 33'h1_ffff_ffff);
            end else begin
                note = notes.pop_front();
                check({pslverr, note.is_rd ? prdata : note.data}, {note.err, note.data});
            end
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0; reset = 1'b1;
        n_fail = 0; n_tests = 0;
        void'($urandom(81));
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rd(A_LOW, 32'h0000_0000);
        rd(A_HIGH, 32'h0000_0000);
        rd(A_CTRL, 32'h0000_0000);
        rd(A_STAT, 32'h0000_0000);
        apb(1'b0, 32'h0000_0010, 32'h0, 1'b1, 32'h0000_0000);
        apb(1'b1, 32'h0000_0014, $urandom, 1'b1, 32'h0000_0000);
        // A well-known check string pins the polynomial independently of the local model.
        wr(A_CTRL, 32'h0000_0003);
        for (int i = 0; i < 9; i++) wr(A_LOW, 32'h31 + i);
        rd(A_HIGH, 32'h0000_0029);
        rd(A_LOW, 32'h0000_00b1);
        apb(1'b1, 32'h0000_0014, $urandom, 1'b1, 32'h0000_0000);
        rd(A_LOW, 32'h0000_00b1);
        for (int m = 0; m < 4; m++) begin
            wr(A_CTRL, {29'h0, m[1], m[0], 1'b1});
            model = m[0] ? crc_pkg::INIT_ONES : crc_pkg::INIT_ZERO;
            rd(A_CTRL, {29'h0, m[1], m[0], 1'b0});
            rd(A_LOW, {24'h0, model[7:0]});
            for (int j = 0; j < 5; j++) begin
                b = 8'($urandom);
                wr(A_LOW, {24'h0, b});
                model = crc_fold(model, b, m[1]);
            end
            wr(A_HIGH, $urandom);
            rd(A_HIGH, {24'h0, model[15:8]});
            rd(A_LOW, {24'h0, model[7:0]});
            wr(A_CTRL, {29'h0, m[1], ~m[0], 1'b0});
            rd(A_LOW, {24'h0, model[7:0]});
            b = 8'($urandom);
            wr(A_LOW, {24'h0, b});
            model = crc_fold(model, b, m[1]);
            rd(A_HIGH, {24'h0, model[15:8]});
            rd(A_LOW, {24'h0, model[7:0]});
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge clock);
        check(33'(notes.size()), 33'h0_0000_0000);
        report_and_stop();
    end

endmodule : tb_crc_calc
